// ==== verilog/ltmc_pkg.sv ====
/*
 * shared constants, codes and helpers for the lin transceiver mode control.
 * assumes a 25 MHz core clock and an spi front end on the same clock.
 */
package ltmc_pkg;

	// core clock rate
	localparam int CLK_MHZ = 25;

	// enabling delay before the first dominant bit, in microseconds
	localparam int EN_DELAY_US = 10;
	// least time, whole cycles already
	localparam int EN_DELAY_CYC = EN_DELAY_US * CLK_MHZ;

	// dominant time needed for a bus wake, in microseconds
	localparam int WAKE_FILT_US = 150;
	localparam int WAKE_FILT_CYC = WAKE_FILT_US * CLK_MHZ;

	// counter width for both timers
	localparam int CNT_W = 12;
	localparam logic [CNT_W-1:0] EN_DELAY_CNT = CNT_W'(EN_DELAY_CYC);
	localparam logic [CNT_W-1:0] WAKE_FILT_CNT = CNT_W'(WAKE_FILT_CYC);

	// transceiver mode field
	localparam int MODE_W = 2;
	localparam logic [MODE_W-1:0] MODE_OFF = 2'h0;
	localparam logic [MODE_W-1:0] MODE_WAKE = 2'h1;
	localparam logic [MODE_W-1:0] MODE_RXO = 2'h2;
	localparam logic [MODE_W-1:0] MODE_NORM = 2'h3;
	localparam logic [MODE_W-1:0] MODE_RST = MODE_OFF;

	// chip operating mode codes
	localparam int CHIP_W = 3;
	localparam logic [CHIP_W-1:0] CHIP_INIT = 3'h0;
	localparam logic [CHIP_W-1:0] CHIP_NORMAL = 3'h1;
	localparam logic [CHIP_W-1:0] CHIP_STOP = 3'h2;
	localparam logic [CHIP_W-1:0] CHIP_SLEEP = 3'h3;
	localparam logic [CHIP_W-1:0] CHIP_RESTART = 3'h4;
	localparam logic [CHIP_W-1:0] CHIP_FAILSAFE = 3'h5;

	// edge log: level bit on top, gap count below
	localparam int EDGE_W = 16;
	localparam int EDGE_DEPTH = 16;
	localparam int GAP_W = 15;
	localparam logic [GAP_W-1:0] GAP_MAX = 15'h7FFF;

	// transceiver state, one-hot
	typedef enum logic [4:0] {
		ST_OFF = 5'h01,
		ST_NORM = 5'h02,
		ST_RXO = 5'h04,
		ST_ARMED = 5'h08,
		ST_WOKEN = 5'h10
	} ltmc_state_e;

	// whether a requested mode may be entered in this chip mode
	function automatic logic mode_allowed(input logic [MODE_W-1:0] m,
		input logic [CHIP_W-1:0] c);
		logic ok;
		ok = 1'b0;
		case (m)
			MODE_OFF: ok = 1'b1;
			MODE_NORM: ok = (c == CHIP_NORMAL);
			MODE_RXO: ok = (c == CHIP_NORMAL) || (c == CHIP_STOP);
			default: ok = (c == CHIP_NORMAL) || (c == CHIP_STOP) ||
				(c == CHIP_SLEEP) || (c == CHIP_RESTART);
		endcase
		return ok;
	endfunction

	// mode field value shown for a state
	function automatic logic [MODE_W-1:0] state_code(input ltmc_state_e s);
		logic [MODE_W-1:0] m;
		m = MODE_OFF;
		case (s)
			ST_NORM: m = MODE_NORM;
			ST_RXO: m = MODE_RXO;
			ST_ARMED: m = MODE_WAKE;
			ST_WOKEN: m = MODE_WAKE;
			default: m = MODE_OFF;
		endcase
		return m;
	endfunction

endpackage

// ==== verilog/ltmc_stream_if.sv ====
/*
 * valid/ready word stream between the mode control core and its fifo.
 * assumes both ends share one clock.
 */
`timescale 1ns/1ns
interface ltmc_stream_if #(parameter int W = 16);
	logic [W-1:0] data; // word carried
	logic valid; // word offered
	logic ready; // word accepted
	modport src (output data, output valid, input ready);
	modport snk (input data, input valid, output ready);
endinterface

// ==== verilog/ltmc_sync.sv ====
/*
 * two flip-flop synchroniser for asynchronous pins.
 * assumes pins idle at the reset value given.
 */
`timescale 1ns/1ns
module ltmc_sync #(
	parameter int W = 3,
	parameter logic [W-1:0] RST = '1
) (
	input wire logic mclk_in,
	input wire logic rst_n_in,
	input wire logic ce_in,
	input wire logic [W-1:0] d_in,
	output logic [W-1:0] q_out
);
	logic [W-1:0] meta_reg; // first stage, read only by q_out

	// two stages, frozen by the clock enable
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			meta_reg <= RST;
			q_out <= RST;
		end else if (ce_in) begin
			meta_reg <= d_in;
			q_out <= meta_reg;
		end
	end
endmodule

// ==== verilog/ltmc_fifo.sv ====
/*
 * word fifo with registered output stage and honest full and empty.
 * assumes DEPTH is a power of two; one clock with a clock enable.
 */
`timescale 1ns/1ns
module ltmc_fifo #(
	parameter int W = 16,
	parameter int DEPTH = 16
) (
	input wire logic mclk_in,
	input wire logic rst_n_in,
	input wire logic ce_in,
	ltmc_stream_if.snk wr_if,
	ltmc_stream_if.src rd_if
);
	localparam int PW = $clog2(DEPTH);
	logic [W-1:0] mem [DEPTH]; // storage
	logic [PW-1:0] wptr_reg; // write index
	logic [PW-1:0] rptr_reg; // read index
	logic [PW:0] count_reg; // words held in memory
	logic full; // no room left
	logic empty; // nothing stored
	logic push; // word taken in
	logic pop; // word moved to output stage

	assign full = (count_reg == (PW+1)'(DEPTH));
	assign empty = (count_reg == '0);
	assign wr_if.ready = !full;
	assign push = wr_if.valid && !full;
	assign pop = !empty && (!rd_if.valid || rd_if.ready);

	// storage write
	always_ff @(posedge mclk_in) begin
		if (ce_in && push) begin
			mem[wptr_reg] <= wr_if.data;
		end
	end

	// pointers and fill level
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			wptr_reg <= '0;
			rptr_reg <= '0;
			count_reg <= '0;
		end else if (ce_in) begin
			if (push) begin
				wptr_reg <= wptr_reg + 1'b1;
			end
			if (pop) begin
				rptr_reg <= rptr_reg + 1'b1;
			end
			if (push && !pop) begin
				count_reg <= count_reg + 1'b1;
			end else if (pop && !push) begin
				count_reg <= count_reg - 1'b1;
			end
		end
	end

	// output stage, held until the drain side accepts
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			rd_if.valid <= 1'b0;
			rd_if.data <= '0;
		end else if (ce_in) begin
			if (pop) begin
				rd_if.valid <= 1'b1;
				rd_if.data <= mem[rptr_reg];
			end else if (rd_if.ready) begin
				rd_if.valid <= 1'b0;
			end
		end
	end
endmodule

// ==== verilog/ltmc_top.sv ====
/*
 * digital mode control of a single-wire bus transceiver: mode state,
 * enabling delay, transmit gating, receive path, bus wake filter and a
 * log of received bus edges through a fifo.
 * assumes the spi front end, chip mode logic and edge reader share
 * mclk_in; tx, bus and chip select come from pins and are synchronised.
 */
`timescale 1ns/1ns
module ltmc_top (
	input wire logic mclk_in,
	input wire logic rst_n_in,
	input wire logic ce_in,
	input wire logic lin_tx_input_in,
	input wire logic bus_in,
	input wire logic cs_n_in,
	input wire logic [ltmc_pkg::MODE_W-1:0] mode_req_in,
	input wire logic mode_wr_in,
	input wire logic [ltmc_pkg::CHIP_W-1:0] chip_mode_in,
	input wire logic edge_ready_in,
	output logic bus_drv_out,
	output logic bus_oe_n_out,
	output logic lin_rx_output_out,
	output logic [ltmc_pkg::MODE_W-1:0] mode_out,
	output logic tx_enabled_out,
	output logic wake_evt_out,
	output logic [ltmc_pkg::EDGE_W-1:0] edge_data_out,
	output logic edge_valid_out,
	output logic edge_overflow_out
);
	import ltmc_pkg::*;

	logic tx_s; // synchronised transmit pin
	logic bus_s; // synchronised bus level, one bit
	logic cs_s; // synchronised chip select, low in frame
	logic cs_prev_reg; // chip select one cycle back
	logic cs_rise; // end of an spi frame
	logic req_pend_reg; // a mode write seen in this frame
	logic [MODE_W-1:0] req_mode_reg; // mode written in this frame
	logic apply; // request taken this cycle
	ltmc_state_e state_reg; // transceiver state
	ltmc_state_e state_next; // state for next cycle
	logic [CHIP_W-1:0] chip_prev_reg; // chip mode one cycle back
	logic chip_enter_rearm; // chip just moved to stop, sleep, fail-safe
	logic [CNT_W-1:0] en_cnt_reg; // enabling delay counter
	logic en_done; // enabling delay elapsed
	logic tx_armed_reg; // transmitter may follow tx
	logic dominant; // drive the bus dominant now
	logic seen_rec_reg; // recessive seen while armed
	logic [CNT_W-1:0] wk_cnt_reg; // dominant length while armed
	logic wake_done; // valid wake pattern ended
	logic bus_prev_reg; // bus level one cycle back
	logic [GAP_W-1:0] gap_reg; // cycles since last logged edge
	logic log_on; // edge logging active
	logic edge_push; // edge offered to fifo

	ltmc_stream_if #(.W(EDGE_W)) edge_wr_if ();
	ltmc_stream_if #(.W(EDGE_W)) edge_rd_if ();

	// pins cross into the clock domain here
	ltmc_sync #(.W(3), .RST(3'h7)) ltmc_sync_inst (
		.mclk_in(mclk_in),
		.rst_n_in(rst_n_in),
		.ce_in(ce_in),
		.d_in({lin_tx_input_in, bus_in, cs_n_in}),
		.q_out({tx_s, bus_s, cs_s})
	);

	// edge log buffer
	ltmc_fifo #(.W(EDGE_W), .DEPTH(EDGE_DEPTH)) ltmc_fifo_inst (
		.mclk_in(mclk_in),
		.rst_n_in(rst_n_in),
		.ce_in(ce_in),
		.wr_if(edge_wr_if),
		.rd_if(edge_rd_if)
	);

	// frame end and request acceptance
	assign cs_rise = cs_s && !cs_prev_reg;
	assign apply = cs_rise && req_pend_reg &&
		mode_allowed(req_mode_reg, chip_mode_in);
	assign chip_enter_rearm = (chip_mode_in != chip_prev_reg) &&
		((chip_mode_in == CHIP_STOP) || (chip_mode_in == CHIP_SLEEP) ||
		(chip_mode_in == CHIP_FAILSAFE));
	assign en_done = (en_cnt_reg == EN_DELAY_CNT);
	assign wake_done = (state_reg == ST_ARMED) && seen_rec_reg && bus_s &&
		(wk_cnt_reg == WAKE_FILT_CNT);

	// spi request capture, only inside a frame
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			cs_prev_reg <= 1'b1;
			req_pend_reg <= 1'b0;
			req_mode_reg <= MODE_RST;
		end else if (ce_in) begin
			cs_prev_reg <= cs_s;
			if (cs_rise) begin
				// frame over, request consumed either way
				req_pend_reg <= 1'b0;
			end else if (mode_wr_in && !cs_s) begin
				// only the spi bits choose the mode
				req_pend_reg <= 1'b1;
				req_mode_reg <= mode_req_in;
			end
		end
	end

	// next transceiver state
	always_comb begin
		state_next = state_reg;
		if (apply) begin
			case (req_mode_reg)
				// off is always reachable
				MODE_OFF: state_next = ST_OFF;
				MODE_NORM: state_next = ST_NORM;
				MODE_RXO: state_next = ST_RXO;
				default: begin
					// a woken transceiver must be toggled first
					if (state_reg != ST_WOKEN) begin
						state_next = ST_ARMED;
					end
				end
			endcase
		end else if (wake_done) begin
			// wake keeps the wake code in the mode field
			state_next = ST_WOKEN;
		end else begin
			case (state_reg)
				ST_NORM, ST_RXO: begin
					// normal and receive-only only in chip normal or stop
					if (chip_mode_in == CHIP_FAILSAFE) begin
						state_next = ST_ARMED;
					end else if ((chip_mode_in != CHIP_NORMAL) &&
						(chip_mode_in != CHIP_STOP)) begin
						state_next = ST_OFF;
					end
				end
				ST_OFF: begin
					// fail-safe forces wake capability on entry only,
					// so off chosen later in fail-safe stays off
					if ((chip_mode_in == CHIP_FAILSAFE) &&
						(chip_mode_in != chip_prev_reg)) begin
						state_next = ST_ARMED;
					end
				end
				ST_WOKEN: begin
					// automatic rearm on entry to a low-power mode
					if (chip_enter_rearm) begin
						state_next = ST_ARMED;
					end
				end
				default: state_next = state_reg;
			endcase
		end
	end

	// state and mode field, off after reset
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			state_reg <= ST_OFF;
			mode_out <= MODE_RST;
			chip_prev_reg <= CHIP_INIT;
		end else if (ce_in) begin
			state_reg <= state_next;
			mode_out <= state_code(state_next);
			chip_prev_reg <= chip_mode_in;
		end
	end

	// enabling delay, restarts on each entry to normal
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			en_cnt_reg <= '0;
			tx_armed_reg <= 1'b0;
		end else if (ce_in) begin
			if (state_reg != ST_NORM) begin
				en_cnt_reg <= '0;
				tx_armed_reg <= 1'b0;
			end else begin
				if (!en_done) begin
					en_cnt_reg <= en_cnt_reg + 1'b1;
				end
				// an early low tx waits for its return high
				if (en_done && tx_s) begin
					tx_armed_reg <= 1'b1;
				end
			end
		end
	end

	// transmit gating: only armed normal mode drives
	assign dominant = (state_reg == ST_NORM) && tx_armed_reg && !tx_s;

	// open-drain driver, enable low while pulling dominant
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			bus_oe_n_out <= 1'b1;
			bus_drv_out <= 1'b1;
			tx_enabled_out <= 1'b0;
		end else if (ce_in) begin
			// receive-only and off never drive
			bus_oe_n_out <= !dominant;
			bus_drv_out <= !dominant;
			tx_enabled_out <= (state_reg == ST_NORM) && tx_armed_reg;
		end
	end

	// receive output per mode
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			lin_rx_output_out <= 1'b1;
		end else if (ce_in) begin
			case (state_reg)
				// dominant low, recessive high
				ST_NORM, ST_RXO: lin_rx_output_out <= bus_s;
				// woken: held low until another mode is applied or a low-power chip mode rearms
				ST_WOKEN: lin_rx_output_out <= 1'b0;
				default: lin_rx_output_out <= 1'b1;
			endcase
		end
	end

	// bus wake filter, runs only while armed
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			seen_rec_reg <= 1'b0;
			wk_cnt_reg <= '0;
			wake_evt_out <= 1'b0;
		end else if (ce_in) begin
			wake_evt_out <= wake_done;
			if (state_reg != ST_ARMED) begin
				// off and other modes ignore the bus
				seen_rec_reg <= 1'b0;
				wk_cnt_reg <= '0;
			end else if (bus_s) begin
				// recessive: the next fall can start a pattern
				seen_rec_reg <= 1'b1;
				wk_cnt_reg <= '0;
			end else if (seen_rec_reg && (wk_cnt_reg != WAKE_FILT_CNT)) begin
				wk_cnt_reg <= wk_cnt_reg + 1'b1;
			end
		end
	end

	// edge log source
	assign log_on = (state_reg == ST_NORM) || (state_reg == ST_RXO);
	assign edge_push = log_on && (bus_s != bus_prev_reg);
	assign edge_wr_if.valid = edge_push;
	assign edge_wr_if.data = {bus_s, gap_reg};
	assign edge_rd_if.ready = edge_ready_in;
	assign edge_data_out = edge_rd_if.data;
	assign edge_valid_out = edge_rd_if.valid;

	// gap counter and overflow flag
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			bus_prev_reg <= 1'b1;
			gap_reg <= '0;
			edge_overflow_out <= 1'b0;
		end else if (ce_in) begin
			bus_prev_reg <= bus_s;
			if (edge_push) begin
				gap_reg <= '0;
			end else if (gap_reg != GAP_MAX) begin
				gap_reg <= gap_reg + 1'b1;
			end
			// lost edge wins over the clear on entering off
			if (edge_push && !edge_wr_if.ready) begin
				edge_overflow_out <= 1'b1;
			end else if (state_next == ST_OFF && state_reg != ST_OFF) begin
				edge_overflow_out <= 1'b0;
			end
		end
	end

	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rst_n_in);

	// checks, next to the logic above
	a_reset_to_off: assert property (
		$rose(rst_n_in) |-> (mode_out == MODE_OFF) && bus_oe_n_out)
		else $error("not off after reset");
	a_off_no_drive: assert property (
		(ce_in && state_reg == ST_OFF) |=> bus_oe_n_out)
		else $error("bus driven in off mode");
	a_off_no_wake: assert property (
		(ce_in && state_reg == ST_OFF) |=> !wake_evt_out)
		else $error("wake raised in off mode");
	a_norm_entry_ok: assert property (
		(ce_in && state_reg != ST_NORM && state_next == ST_NORM) |->
		cs_rise && (chip_mode_in == CHIP_NORMAL))
		else $error("normal entered outside chip normal or frame end");
	a_chip_mode_ok: assert property (
		(ce_in && (state_next == ST_NORM || state_next == ST_RXO)) |->
		(chip_mode_in == CHIP_NORMAL || chip_mode_in == CHIP_STOP))
		else $error("normal or receive-only in wrong chip mode");
	a_tx_follows: assert property (
		(ce_in && state_reg == ST_NORM && tx_armed_reg) |=>
		(bus_oe_n_out == $past(tx_s)))
		else $error("driver does not follow tx");
	a_enable_hold: assert property (
		(ce_in && state_reg == ST_NORM && !en_done) |=>
		bus_oe_n_out ##0 !tx_enabled_out)
		else $error("bus driven during enable delay");
	a_rx_path: assert property (
		(ce_in && (state_reg == ST_RXO || state_reg == ST_NORM)) |=>
		(lin_rx_output_out == $past(bus_s)) &&
		($past(state_reg) != ST_RXO || bus_oe_n_out))
		else $error("receive path or driver wrong");
	a_woken_rx_low: assert property (
		(ce_in && state_reg == ST_WOKEN) |=>
		!lin_rx_output_out && (mode_out == MODE_WAKE || $past(apply)))
		else $error("woken state not shown");
	a_wake_filter: assert property (
		$rose(wake_evt_out) |-> $past(wk_cnt_reg) == WAKE_FILT_CNT &&
		$past(bus_s) && $past(state_reg) == ST_ARMED)
		else $error("wake without full dominant pattern");
	a_freeze_hold: assert property ( // clock enable
		!ce_in |=> $stable(state_reg) && $stable(mode_out) &&
		$stable(lin_rx_output_out) && $stable(bus_oe_n_out))
		else $error("state moved while clock enable low");
endmodule

// ==== tb/ltmc_host_model.sv ====
/*
 * behavioural host controller on the transmit pin of the mode control.
 * assumes the bench asks for dominant or recessive on dom_req_in and
 * that all drives change on the falling edge of mclk_in.
 */
`timescale 1ns/1ns
module ltmc_host_model #(
	parameter int BIT_CYC = 2404 // one bit at 10.4 kbit/s, 25 MHz
) (
	input wire logic mclk_in,
	input wire logic dom_req_in,
	output logic tx_out,
	output logic busy_out
);
	import ltmc_pkg::*;
	int hold; // cycles left of the current bit

	// pin idles recessive from power-up
	initial begin
		tx_out = 1'b1;
		hold = 0;
	end

	// still inside a bit, no new level yet
	assign busy_out = (hold != 0);

	// a new level only at a bit boundary, then held for one bit
	always @(negedge mclk_in) begin
		if (hold != 0) begin
			hold <= hold - 1;
		end else if (tx_out != !dom_req_in) begin
			tx_out <= !dom_req_in;
			hold <= BIT_CYC - 1;
		end
	end
endmodule

// ==== tb/ltmc_top_test.sv ====
/*
 * self-checking bench for the transceiver mode control top.
 * assumes a pulled-up single-wire bus shared by the device and one peer.
 */
`timescale 1ns/1ns
module ltmc_top_test;
	import ltmc_pkg::*;
	localparam int LIMIT = 40000; // cycle ceiling for the whole run
	logic mclk_in = 1'b0;
	logic rst_n = 1'b0;
	logic cs_n = 1'b1;
	logic [MODE_W-1:0] mode_req = MODE_OFF;
	logic mode_wr = 1'b0;
	logic [CHIP_W-1:0] chip_mode = CHIP_NORMAL;
	logic edge_ready = 1'b1;
	logic ce = 1'b1; // clock enable of the design
	logic peer_dom = 1'b0; // another node pulls dominant
	logic dom_req = 1'b0; // host wants dominant
	logic tx, busy, bus_wire, drv, oe_n, rx, tx_en, evt, e_valid, e_ovf;
	logic [MODE_W-1:0] mode;
	logic [EDGE_W-1:0] e_data;
	int errors = 0;
	int checked = 0;
	int cycles = 0;

	// clock, 40 ns period
	always #20 mclk_in = !mclk_in;

	// wired bus: dominant if anyone drives low
	assign bus_wire = !((!oe_n && !drv) || peer_dom);

	ltmc_top ltmc_top_inst (.mclk_in(mclk_in), .rst_n_in(rst_n),
		.ce_in(ce), .lin_tx_input_in(tx), .bus_in(bus_wire),
		.cs_n_in(cs_n), .mode_req_in(mode_req), .mode_wr_in(mode_wr),
		.chip_mode_in(chip_mode), .edge_ready_in(edge_ready),
		.bus_drv_out(drv), .bus_oe_n_out(oe_n), .lin_rx_output_out(rx),
		.mode_out(mode), .tx_enabled_out(tx_en), .wake_evt_out(evt),
		.edge_data_out(e_data), .edge_valid_out(e_valid),
		.edge_overflow_out(e_ovf));

	ltmc_host_model ltmc_host_model_inst (.mclk_in(mclk_in),
		.dom_req_in(dom_req), .tx_out(tx), .busy_out(busy));

	// closing report and end of run
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// hang guard
	always @(posedge mclk_in) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			errors++;
			give_verdict();
		end
	end

	// one comparison of a value
	task automatic chk(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("wrong value %s exp %h got %h", what, exp, got);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(negedge mclk_in);
	endtask

	// one spi frame carrying a mode request
	task automatic frame(input logic [MODE_W-1:0] code);
		cs_n <= 1'b0;
		tick(3);
		mode_req <= code;
		mode_wr <= 1'b1;
		tick(1);
		mode_wr <= 1'b0;
		cs_n <= 1'b1;
		tick(4);
	endtask

	// wait until the host pin shows the asked level, bit finished
	task automatic wait_idle;
		int i;
		tick(2);
		for (i = 0; i < 6000 && (busy || tx != !dom_req); i++)
			tick(1);
	endtask

	// peer dominant pulse, then count wake pulses afterwards
	task automatic pulse_count(input int len, output int c);
		int i;
		c = 0;
		peer_dom <= 1'b1;
		tick(len);
		peer_dom <= 1'b0;
		for (i = 0; i < 20; i++) begin
			tick(1);
			if (evt === 1'b1)
				c++;
		end
	endtask

	// state straight after reset
	task automatic t_reset;
		chk("mode", MODE_OFF, mode);
		chk("oe_n", 1, oe_n);
		chk("rx", 1, rx);
		chk("tx_en", 0, tx_en);
		$display("test reset done");
	endtask

	// long dominant in off raises nothing
	task automatic t_off_wake;
		int c;
		pulse_count(WAKE_FILT_CYC + 50, c);
		chk("wake count", 0, 16'(c));
		chk("rx", 1, rx);
		chk("oe_n", 1, oe_n);
		$display("test off wake done");
	endtask

	// requests the chip mode does not allow, and a stray write
	task automatic t_refused;
		chip_mode <= CHIP_STOP;
		frame(MODE_NORM);
		chk("mode", MODE_OFF, mode);
		chip_mode <= CHIP_SLEEP;
		frame(MODE_RXO);
		chk("mode", MODE_OFF, mode);
		chip_mode <= CHIP_STOP;
		mode_req <= MODE_RXO;
		mode_wr <= 1'b1;
		tick(1);
		mode_wr <= 1'b0;
		tick(6);
		chk("mode", MODE_OFF, mode);
		frame(MODE_RXO);
		chk("mode", MODE_RXO, mode);
		$display("test refused done");
	endtask

	// receive-only: fill the edge log past full, then drain it
	task automatic t_fifo;
		int i;
		int n;
		edge_ready <= 1'b0;
		dom_req <= 1'b1;
		for (i = 0; i < 20; i++) begin
			peer_dom <= !peer_dom;
			tick(6);
			if (i == 0)
				chk("rx", 0, rx);
		end
		chk("oe_n", 1, oe_n);
		chk("overflow", 1, e_ovf);
		chk("valid", 1, e_valid);
		chk("first level", 0, e_data[EDGE_W-1]);
		n = 0;
		for (i = 0; i < 60; i++) begin
			if (e_valid === 1'b1)
				n++;
			// second word: edges 6 cycles apart, 5 idle cycles between
			if (i == 1)
				chk("gap", 16'(5), 16'(e_data[GAP_W-1:0]));
			edge_ready <= 1'b1;
			tick(1);
		end
		chk("words", 16'(EDGE_DEPTH + 1), 16'(n));
		chk("valid", 0, e_valid);
		dom_req <= 1'b0;
		frame(MODE_OFF);
		chk("overflow", 0, e_ovf);
		chk("mode", MODE_OFF, mode);
		wait_idle();
		$display("test fifo done");
	endtask

	// normal mode: early dominant blocked, then drive and receive
	task automatic t_normal;
		int i;
		chip_mode <= CHIP_NORMAL;
		frame(MODE_NORM);
		chk("mode", MODE_NORM, mode);
		dom_req <= 1'b1;
		tick(EN_DELAY_CYC + 50);
		chk("oe_n", 1, oe_n);
		chk("tx_en", 0, tx_en);
		dom_req <= 1'b0;
		wait_idle();
		chk("tx_en", 1, tx_en);
		dom_req <= 1'b1;
		for (i = 0; i < 10 && tx; i++)
			tick(1);
		tick(4);
		chk("oe_n", 0, oe_n);
		chk("drv", 0, drv);
		tick(4);
		chk("rx", 0, rx);
		dom_req <= 1'b0;
		wait_idle();
		chk("oe_n", 1, oe_n);
		chk("rx", 1, rx);
		ce <= 1'b0;
		peer_dom <= 1'b1;
		tick(8);
		chk("rx frozen", 1, rx);
		chk("mode frozen", MODE_NORM, mode);
		ce <= 1'b1;
		tick(4);
		chk("rx", 0, rx);
		peer_dom <= 1'b0;
		tick(4);
		chk("rx", 1, rx);
		chip_mode <= CHIP_SLEEP;
		tick(4);
		chk("mode", MODE_OFF, mode);
		$display("test normal done");
	endtask

	// wake capable: short pulse ignored, long one wakes
	task automatic t_wake;
		int c;
		chip_mode <= CHIP_NORMAL;
		frame(MODE_WAKE);
		chk("mode", MODE_WAKE, mode);
		pulse_count(100, c);
		chk("wake count", 0, 16'(c));
		pulse_count(WAKE_FILT_CYC + 50, c);
		chk("wake count", 1, 16'(c));
		chk("mode", MODE_WAKE, mode);
		chk("rx", 0, rx);
		tick(50);
		chk("rx", 0, rx);
		chip_mode <= CHIP_STOP;
		tick(4);
		pulse_count(WAKE_FILT_CYC + 50, c);
		chk("wake count", 1, 16'(c));
		frame(MODE_OFF);
		chk("rx", 1, rx);
		chk("mode", MODE_OFF, mode);
		chip_mode <= CHIP_FAILSAFE;
		tick(4);
		chk("mode", MODE_WAKE, mode);
		frame(MODE_OFF);
		tick(8);
		chk("mode", MODE_OFF, mode);
		$display("test wake done");
	endtask

	// main sequence
	initial begin
		tick(12);
		rst_n <= 1'b1;
		tick(2);
		t_reset();
		t_off_wake();
		t_refused();
		t_fifo();
		t_normal();
		t_wake();
		give_verdict();
	end
endmodule
